// ===== mcsc_pkg.sv
/*
 Shared constants for the channel select logic of a 16-to-1 analog multiplexer:
 widths, variant codes, timing counts and reset values.
 Assumes a 20 MHz system clock on both ends.
*/
package mcsc_pkg;
   localparam int ADDR_W = 4;
   localparam int NUM_CH = 16;
   localparam int SR_W   = 8;

   // Interface variant codes
   localparam logic [1:0] VAR_ASYNC  = 2'h0;
   localparam logic [1:0] VAR_LATCH  = 2'h1;
   localparam logic [1:0] VAR_SERIAL = 2'h2;

   // Timing
   localparam int SYS_CLK_NS      = 50;
   localparam int SWITCH_DELAY_NS = 100;
   localparam int SWITCH_CYC      = (SWITCH_DELAY_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int SPI_HALF_CYC    = 4;
   localparam int PAR_HOLD_CYC    = 8;
   localparam int RST_HOLD_CYC    = 4;

   // Reset values
   localparam logic [ADDR_W-1:0] ADDR_RST  = 4'h0;
   localparam logic [SR_W-1:0]   SHIFT_RST = 8'h00;

   typedef enum logic [1:0] {
      SW_HIZ,
      SW_CLOSED,
      SW_BREAK
   } mcsc_sw_state_t;

   typedef enum logic [2:0] {
      H_RESET,
      H_IDLE,
      H_PAR,
      H_LOW,
      H_HIGH,
      H_END,
      H_GAP
   } mcsc_host_state_t;
endpackage : mcsc_pkg

// ===== mcsc_if.sv
/*
 Pin-level link between the multiplexer select logic and its host.
 Carries the parallel address, chip select, latch strobe, serial pins and the reset pin.
 Assumes the host makes the serial clock; all pins are one-way.
*/
`timescale 1ns/1ps
interface mcsc_if;
   logic                        sclk;
   logic                        ss_n;
   logic                        mosi;
   logic                        miso;
   logic [mcsc_pkg::ADDR_W-1:0] addr;
   logic                        cs_n;
   logic                        parallel_latch_strobe;
   logic                        reset_n;

   modport device (
      input  sclk,
      input  ss_n,
      input  mosi,
      output miso,
      input  addr,
      input  cs_n,
      input  parallel_latch_strobe,
      input  reset_n
   );

   modport host (
      output sclk,
      output ss_n,
      output mosi,
      input  miso,
      output addr,
      output cs_n,
      output parallel_latch_strobe,
      output reset_n
   );
endinterface : mcsc_if

// ===== mcsc_device.sv
/*
 Device end: channel select decode with break-before-make switch control for a
 16-to-1 multiplexer, in one of three interface variants chosen by VARIANT.
 The serial shift register runs on the link clock; decode and switch timing run on
 sys_clk_i. Assumes the host keeps the link pins as the host end does.
*/
// How it works
// RQ1 - Async variant decodes the four address lines
// RQ2 - Host sweeps all sixteen addresses after power-up
// RQ3 - Host holds address static; change means request
// RQ4 - New channel connects about 100 ns later
// RQ5 - Host settles all address bits within 18 ns
// RQ6 - Address accepted only while chip select low
// RQ7 - Old channel opens before new one closes
// RQ8 - Latch strobe rising edge registers the address
// RQ9 - Eight-bit shift register, MOSI on SCLK rise
// RQ10 - Low four register bits form channel address
// RQ11 - Most significant bit first, first is bit 7
// RQ12 - MISO shows shifted bits eight clocks later
// RQ13 - MISO shows bit 7, advances on falling
// RQ14 - Master holds slave select low while shifting
// RQ15 - Decode updates when slave select returns high
// RQ16 - Device is slave; master drives serial pins
// RQ17 - Reset acts without any clock edge
// RQ18 - Reset low opens all switches, high impedance
// RQ19 - Reset selects channel zero, driven after release
// RQ20 - System should hold reset low at power-up
// RQ21 - Odd bit count decodes lowest four bits
`timescale 1ns/1ps
module mcsc_device #(
   parameter logic [1:0] VARIANT    = mcsc_pkg::VAR_SERIAL,
   parameter int         SWITCH_CYC = mcsc_pkg::SWITCH_CYC
) (
   input  wire logic                          sys_clk_i,
   input  wire logic                          sys_rst_i,
   mcsc_if.device                             link,
   output logic      [mcsc_pkg::NUM_CH-1:0]   channel_en_o,
   output logic      [mcsc_pkg::ADDR_W-1:0]   selected_o,
   output logic                               common_output_hiz_o,
   output logic                               switching_o
);
   localparam int AW   = mcsc_pkg::ADDR_W;
   localparam int CW   = mcsc_pkg::NUM_CH;
   localparam int SW   = mcsc_pkg::SR_W;
   localparam int PW   = AW + 3;
   localparam int CNTW = $clog2(SWITCH_CYC + 1);

   localparam logic [CNTW-1:0] CNT_LOAD = CNTW'(SWITCH_CYC - 1);
   localparam logic [CW-1:0]   ONE_HOT0 = {{(CW - 1){1'b0}}, 1'b1};
   localparam logic [PW-1:0]   PINS_RST = {1'b0, 1'b1, 1'b1, mcsc_pkg::ADDR_RST};

   // Link clock domain
   logic [SW-1:0] shift_q;
   logic          miso_q;

   // System clock domain
   logic [PW-1:0]           pins_a_q;
   logic [PW-1:0]           pins_b_q;
   logic [PW-1:0]           pins_c_q;
   logic [AW-1:0]           target_q;
   logic [AW-1:0]           sel_q;
   logic [CW-1:0]           en_q;
   logic                    hiz_q;
   logic [CNTW-1:0]         cnt_q;
   mcsc_pkg::mcsc_sw_state_t state_q;

   logic          req;
   logic [AW-1:0] req_addr;
   logic [AW-1:0] addr_b;
   logic [AW-1:0] addr_c;
   logic          ss_b;
   logic          ss_c;
   logic          cs_b;
   logic          strobe_b;
   logic          strobe_c;

   // Serial shift register, slave only, first bit ends up in bit 7
   always_ff @(posedge link.sclk or negedge link.reset_n)
   begin
      if (!link.reset_n)
      begin
         shift_q <= mcsc_pkg::SHIFT_RST; // RQ17
      end
      else if (!link.ss_n)
      begin
         shift_q <= {shift_q[SW-2:0], link.mosi}; // RQ9 RQ11 RQ16
      end
   end

   // Serial out: bit 7 stands before the first edge, next bit on each fall
   always_ff @(negedge link.sclk or negedge link.reset_n)
   begin
      if (!link.reset_n)
      begin
         miso_q <= 1'b0; // RQ17
      end
      else if (!link.ss_n)
      begin
         miso_q <= shift_q[SW-1]; // RQ12 RQ13
      end
   end

   assign link.miso = miso_q;

   // Pin synchronisers: strobe, chip select, slave select, address
   always_ff @(posedge sys_clk_i or negedge link.reset_n)
   begin
      if (!link.reset_n)
      begin
         pins_a_q <= PINS_RST;
         pins_b_q <= PINS_RST;
         pins_c_q <= PINS_RST;
      end
      else if (sys_rst_i)
      begin
         pins_a_q <= PINS_RST;
         pins_b_q <= PINS_RST;
         pins_c_q <= PINS_RST;
      end
      else
      begin
         pins_a_q <= {link.parallel_latch_strobe, link.cs_n, link.ss_n, link.addr};
         pins_b_q <= pins_a_q;
         pins_c_q <= pins_b_q;
      end
   end

   assign addr_b   = pins_b_q[AW-1:0];
   assign addr_c   = pins_c_q[AW-1:0];
   assign ss_b     = pins_b_q[AW];
   assign ss_c     = pins_c_q[AW];
   assign cs_b     = pins_b_q[AW+1];
   assign strobe_b = pins_b_q[AW+2];
   assign strobe_c = pins_c_q[AW+2];

   // Channel request from the selected variant
   always_comb
   begin
      req      = 1'b0;
      req_addr = target_q;
      if (VARIANT == mcsc_pkg::VAR_ASYNC)
      begin
         // Settled address that differs from the last accepted one
         req      = !cs_b && (addr_b == addr_c) && (addr_b != target_q); // RQ1 RQ3 RQ5 RQ6
         req_addr = addr_b; // RQ1
      end
      else if (VARIANT == mcsc_pkg::VAR_LATCH)
      begin
         req      = strobe_b && !strobe_c; // RQ8
         req_addr = addr_b; // RQ8
      end
      else
      begin
         // Shift register is still while slave select is high
         req      = ss_b && !ss_c; // RQ14 RQ15
         req_addr = shift_q[AW-1:0]; // RQ10 RQ21
      end
   end

   // Break-before-make switch control
   always_ff @(posedge sys_clk_i or negedge link.reset_n)
   begin
      if (!link.reset_n)
      begin
         state_q  <= mcsc_pkg::SW_HIZ; // RQ17 RQ18
         target_q <= mcsc_pkg::ADDR_RST; // RQ19
         sel_q    <= mcsc_pkg::ADDR_RST; // RQ19
         en_q     <= '0; // RQ18
         hiz_q    <= 1'b1; // RQ18
         cnt_q    <= '0;
      end
      else if (sys_rst_i)
      begin
         state_q  <= mcsc_pkg::SW_HIZ;
         target_q <= mcsc_pkg::ADDR_RST;
         sel_q    <= mcsc_pkg::ADDR_RST;
         en_q     <= '0;
         hiz_q    <= 1'b1;
         cnt_q    <= '0;
      end
      else
      begin
         case (state_q)
            mcsc_pkg::SW_HIZ:
            begin
               // Leave high impedance on channel zero
               hiz_q   <= 1'b0; // RQ19
               en_q    <= ONE_HOT0; // RQ19
               state_q <= mcsc_pkg::SW_CLOSED;
            end
            mcsc_pkg::SW_CLOSED:
            begin
               if (req)
               begin
                  en_q     <= '0; // RQ7
                  target_q <= req_addr;
                  cnt_q    <= CNT_LOAD; // RQ4
                  state_q  <= mcsc_pkg::SW_BREAK;
               end
            end
            mcsc_pkg::SW_BREAK:
            begin
               if (req)
               begin
                  // New request while open restarts the wait
                  target_q <= req_addr;
                  cnt_q    <= CNT_LOAD; // RQ4
               end
               else if (cnt_q == '0)
               begin
                  en_q    <= ONE_HOT0 << target_q; // RQ4 RQ7
                  sel_q   <= target_q;
                  state_q <= mcsc_pkg::SW_CLOSED;
               end
               else
               begin
                  cnt_q <= cnt_q - CNTW'(1);
               end
            end
            default:
            begin
               state_q <= mcsc_pkg::SW_HIZ;
            end
         endcase
      end
   end

   // Status flops for the user side
   always_ff @(posedge sys_clk_i or negedge link.reset_n)
   begin
      if (!link.reset_n)
      begin
         switching_o <= 1'b0;
      end
      else if (sys_rst_i)
      begin
         switching_o <= 1'b0;
      end
      else
      begin
         switching_o <= (state_q == mcsc_pkg::SW_BREAK);
      end
   end

   assign channel_en_o        = en_q;
   assign selected_o          = sel_q;
   assign common_output_hiz_o = hiz_q;
endmodule : mcsc_device

// ===== mcsc_host.sv
/*
 Host end: drives the multiplexer select pins for the chosen variant, makes the
 serial clock from sys_clk_i by a divider, sweeps all addresses after reset for
 the async variant, and returns the bits read back on MISO.
 Assumes one request at a time, accepted only while busy_o is low.
*/
`timescale 1ns/1ps
module mcsc_host #(
   parameter logic [1:0] VARIANT  = mcsc_pkg::VAR_SERIAL,
   parameter int         HALF_CYC = mcsc_pkg::SPI_HALF_CYC,
   parameter int         HOLD_CYC = mcsc_pkg::PAR_HOLD_CYC,
   parameter int         RST_CYC  = mcsc_pkg::RST_HOLD_CYC
) (
   input  wire logic                          sys_clk_i,
   input  wire logic                          sys_rst_i,
   mcsc_if.host                               link,
   input  wire logic                          req_i,
   input  wire logic [mcsc_pkg::ADDR_W-1:0]   req_addr_i,
   output logic                               busy_o,
   output logic                               init_done_o,
   output logic      [mcsc_pkg::SR_W-1:0]     echo_o
);
   localparam int AW   = mcsc_pkg::ADDR_W;
   localparam int SW   = mcsc_pkg::SR_W;
   localparam int CNTW = $clog2(HOLD_CYC + HALF_CYC + RST_CYC + 1);

   localparam logic [CNTW-1:0] HALF_LOAD = CNTW'(HALF_CYC - 1);
   localparam logic [CNTW-1:0] HOLD_LOAD = CNTW'(HOLD_CYC - 1);
   localparam logic [CNTW-1:0] HOLD_MID  = CNTW'(HOLD_CYC / 2);

   mcsc_pkg::mcsc_host_state_t state_q;
   logic [CNTW-1:0] cnt_q;
   logic [2:0]      bit_q;
   logic [SW-1:0]   tx_q;
   logic [SW-1:0]   rx_q;
   logic [AW-1:0]   sweep_q;
   logic            miso_a_q;
   logic            miso_b_q;

   always_ff @(posedge sys_clk_i)
   begin
      miso_a_q <= link.miso;
      miso_b_q <= miso_a_q;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         // Reset pin held low while the system comes up
         state_q     <= mcsc_pkg::H_RESET; // RQ20
         cnt_q       <= CNTW'(RST_CYC - 1);
         bit_q       <= '0;
         tx_q        <= mcsc_pkg::SHIFT_RST;
         rx_q        <= mcsc_pkg::SHIFT_RST;
         sweep_q     <= mcsc_pkg::ADDR_RST;
         init_done_o <= (VARIANT != mcsc_pkg::VAR_ASYNC);
         busy_o      <= 1'b1;
         echo_o      <= mcsc_pkg::SHIFT_RST;
         link.reset_n               <= 1'b0;
         link.sclk                  <= 1'b0;
         link.ss_n                  <= 1'b1;
         link.mosi                  <= 1'b0;
         link.addr                  <= mcsc_pkg::ADDR_RST;
         link.cs_n                  <= 1'b1;
         link.parallel_latch_strobe <= 1'b0;
      end
      else
      begin
         case (state_q)
            mcsc_pkg::H_RESET:
            begin
               if (cnt_q == '0)
               begin
                  link.reset_n <= 1'b1;
                  state_q      <= mcsc_pkg::H_GAP;
                  cnt_q        <= HOLD_LOAD;
               end
               else
               begin
                  cnt_q <= cnt_q - CNTW'(1);
               end
            end
            mcsc_pkg::H_IDLE:
            begin
               if (!init_done_o)
               begin
                  // Power-up sweep through every address
                  link.addr <= sweep_q; // RQ2
                  link.cs_n <= 1'b0; // RQ2
                  cnt_q     <= HOLD_LOAD;
                  state_q   <= mcsc_pkg::H_PAR;
               end
               else if (req_i)
               begin
                  busy_o <= 1'b1;
                  if (VARIANT == mcsc_pkg::VAR_SERIAL)
                  begin
                     tx_q      <= {{(SW - AW){1'b0}}, req_addr_i}; // RQ10
                     link.mosi <= 1'b0; // RQ11
                     link.ss_n <= 1'b0; // RQ14
                     bit_q     <= '0;
                     cnt_q     <= HALF_LOAD;
                     state_q   <= mcsc_pkg::H_LOW;
                  end
                  else
                  begin
                     // All address bits change in one edge
                     link.addr <= req_addr_i; // RQ3 RQ5
                     link.cs_n <= (VARIANT != mcsc_pkg::VAR_ASYNC);
                     cnt_q     <= HOLD_LOAD;
                     state_q   <= mcsc_pkg::H_PAR;
                  end
               end
            end
            mcsc_pkg::H_PAR:
            begin
               if (VARIANT == mcsc_pkg::VAR_LATCH && cnt_q == HOLD_MID)
               begin
                  link.parallel_latch_strobe <= 1'b1;
               end
               if (cnt_q == '0)
               begin
                  link.parallel_latch_strobe <= 1'b0;
                  link.cs_n <= 1'b1;
                  if (VARIANT == mcsc_pkg::VAR_ASYNC && init_done_o)
                  begin
                     // Disturb the idle address; device must keep its channel
                     link.addr <= ~link.addr; // RQ6
                  end
                  if (!init_done_o)
                  begin
                     sweep_q     <= sweep_q + AW'(1);
                     init_done_o <= (sweep_q == {AW{1'b1}});
                  end
                  busy_o  <= 1'b0;
                  state_q <= mcsc_pkg::H_IDLE;
               end
               else
               begin
                  cnt_q <= cnt_q - CNTW'(1);
               end
            end
            mcsc_pkg::H_LOW:
            begin
               if (cnt_q == '0)
               begin
                  link.sclk <= 1'b1;
                  cnt_q     <= HALF_LOAD;
                  state_q   <= mcsc_pkg::H_HIGH;
               end
               else
               begin
                  cnt_q <= cnt_q - CNTW'(1);
               end
            end
            mcsc_pkg::H_HIGH:
            begin
               if (cnt_q == '0)
               begin
                  rx_q      <= {rx_q[SW-2:0], miso_b_q};
                  link.sclk <= 1'b0;
                  cnt_q     <= HALF_LOAD;
                  if (bit_q == 3'h7)
                  begin
                     state_q <= mcsc_pkg::H_END;
                  end
                  else
                  begin
                     bit_q     <= bit_q + 3'h1;
                     tx_q      <= {tx_q[SW-2:0], 1'b0};
                     link.mosi <= tx_q[SW-2]; // RQ11
                     state_q   <= mcsc_pkg::H_LOW;
                  end
               end
               else
               begin
                  cnt_q <= cnt_q - CNTW'(1);
               end
            end
            mcsc_pkg::H_END:
            begin
               if (cnt_q == '0)
               begin
                  link.ss_n <= 1'b1; // RQ14
                  echo_o    <= rx_q;
                  cnt_q     <= HOLD_LOAD;
                  state_q   <= mcsc_pkg::H_GAP;
               end
               else
               begin
                  cnt_q <= cnt_q - CNTW'(1);
               end
            end
            mcsc_pkg::H_GAP:
            begin
               if (cnt_q == '0)
               begin
                  busy_o  <= 1'b0;
                  state_q <= mcsc_pkg::H_IDLE;
               end
               else
               begin
                  cnt_q <= cnt_q - CNTW'(1);
               end
            end
            default:
            begin
               state_q <= mcsc_pkg::H_IDLE;
            end
         endcase
      end
   end
endmodule : mcsc_host

// ===== mcsc_checker.sv
/*
 Concurrent checks on the serial link between the multiplexer select host and device,
 plus the device's switch outputs for that pair.
 Assumes sclk, ss_n and mosi change just after a sys_clk_i edge, as the host makes them.
*/
`timescale 1ns/1ps
module mcsc_checker (
   input wire logic                        sys_clk_i,
   input wire logic                        sys_rst_i,
   input wire logic                        sclk,
   input wire logic                        ss_n,
   input wire logic                        mosi,
   input wire logic                        miso,
   input wire logic                        reset_n,
   input wire logic [mcsc_pkg::NUM_CH-1:0] channel_en_o,
   input wire logic                        common_output_hiz_o
);
   logic [mcsc_pkg::SR_W-1:0] sr_q;
   logic [3:0]                rise_cnt_q;
   logic                      any_on;

   assign any_on = |channel_en_o;

   // Model of the device shift register
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i || !reset_n)
         sr_q <= '0;
      else if (!ss_n && $rose(sclk))
         sr_q <= {sr_q[mcsc_pkg::SR_W-2:0], mosi};
   end

   // Rising serial clock edges within one frame
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i || ss_n)
         rise_cnt_q <= 4'h0;
      else if ($rose(sclk))
         rise_cnt_q <= rise_cnt_q + 4'h1;
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   a_one_switch_max: assert property ($onehot0(channel_en_o))
      else $error("more than one channel closed");
   a_break_first: assert property (any_on && $changed(channel_en_o) |->
      $past(channel_en_o) == '0) else $error("channel changed without opening first");
   a_break_hold: assert property ($fell(any_on) |-> (!any_on)[*2])
      else $error("break interval too short");
   a_serial_decode: assert property ($rose(ss_n) |-> ##[2:10]
      channel_en_o == (16'h0001 << sr_q[3:0])) else $error("serial decode wrong");
   a_decode_not_early: assert property ($rose(ss_n) |=> $stable(channel_en_o))
      else $error("switch moved too soon after frame end");
   a_frame_no_decode: assert property (!ss_n && $past(ss_n) == 1'b0 |->
      $stable(channel_en_o)) else $error("switch moved inside a frame");
   a_miso_first: assert property ($fell(ss_n) |-> miso == sr_q[mcsc_pkg::SR_W-1])
      else $error("miso not showing bit 7 before first clock");
   a_miso_advance: assert property (!ss_n && $fell(sclk) |->
      miso == sr_q[mcsc_pkg::SR_W-1]) else $error("miso did not advance on falling edge");
   a_sclk_idle: assert property (ss_n |-> !sclk)
      else $error("serial clock active outside frame");
   a_eight_clocks: assert property ($rose(ss_n) |-> rise_cnt_q == 4'h8)
      else $error("frame without eight clock edges");
   a_reset_open: assert property (!reset_n |-> common_output_hiz_o &&
      channel_en_o == '0) else $error("switch closed during reset");
   a_release_ch0: assert property ($rose(reset_n) |=> !common_output_hiz_o &&
      channel_en_o == 16'h0001) else $error("channel zero not driven after reset");
endmodule : mcsc_checker

// ===== tb.sv
/*
 Testbench: three host/device pairs, one per interface variant, joined by links.
 Assumes both ends run on sys_clk_i and the host makes the serial clock itself.
*/
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         failures++; \
         $display("unexpected at %0t: %s", $time, msg); \
      end \
   end

module tb;
   localparam int NV = 3;

   logic                        sys_clk_i;
   logic                        sys_rst_i;
   logic                        req       [NV];
   logic [mcsc_pkg::ADDR_W-1:0] raddr     [NV];
   logic                        busy      [NV];
   logic                        init_done [NV];
   logic [mcsc_pkg::SR_W-1:0]   echo      [NV];
   logic [mcsc_pkg::NUM_CH-1:0] ch_en     [NV];
   logic [mcsc_pkg::ADDR_W-1:0] sel       [NV];
   logic                        hiz       [NV];
   logic                        sw        [NV];
   int                          failures;
   int                          n_compared;
   int                          seed;
   int                          sw_cyc [NV];
   logic [mcsc_pkg::ADDR_W-1:0] last_async;
   logic [mcsc_pkg::ADDR_W-1:0] last_ser;
   logic [31:0]                 rnd;
   logic [mcsc_pkg::ADDR_W-1:0] corners [6] = '{4'h0, 4'hf, 4'hf, 4'h1, 4'h8, 4'h7};

   mcsc_if lk [NV] ();

   // Index 0 async, 1 latch, 2 serial, matching the variant codes
   for (genvar g = 0; g < NV; g++)
   begin : gen_v
      mcsc_host #(.VARIANT(2'(g))) u_mcsc_host (
         .sys_clk_i   (sys_clk_i),
         .sys_rst_i   (sys_rst_i),
         .link        (lk[g]),
         .req_i       (req[g]),
         .req_addr_i  (raddr[g]),
         .busy_o      (busy[g]),
         .init_done_o (init_done[g]),
         .echo_o      (echo[g])
      );
      mcsc_device #(.VARIANT(2'(g))) u_mcsc_device (
         .sys_clk_i           (sys_clk_i),
         .sys_rst_i           (sys_rst_i),
         .link                (lk[g]),
         .channel_en_o        (ch_en[g]),
         .selected_o          (sel[g]),
         .common_output_hiz_o (hiz[g]),
         .switching_o         (sw[g])
      );
   end

   mcsc_checker u_mcsc_checker (
      .sys_clk_i           (sys_clk_i),
      .sys_rst_i           (sys_rst_i),
      .sclk                (lk[2].sclk),
      .ss_n                (lk[2].ss_n),
      .mosi                (lk[2].mosi),
      .miso                (lk[2].miso),
      .reset_n             (lk[2].reset_n),
      .channel_en_o        (ch_en[2]),
      .common_output_hiz_o (hiz[2])
   );

   initial
   begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   function automatic logic [mcsc_pkg::NUM_CH-1:0] exp_onehot(input logic [3:0] a);
      return 16'h0001 << a;
   endfunction : exp_onehot

   // Cycles each pair spends in the break interval
   always @(negedge sys_clk_i)
      foreach (sw_cyc[i])
         if (sw[i] === 1'b1)
            sw_cyc[i]++;

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #2;
   endtask : tick

   task automatic summarize();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize

   task automatic wait_idle(input int v);
      int k = 0;
      while ((busy[v] !== 1'b0 || init_done[v] !== 1'b1) && k < 3000)
      begin
         tick(1);
         k++;
      end
      if (k >= 3000)
      begin
         failures++;
         $display("unexpected at %0t: host %0d stays busy", $time, v);
      end
   endtask : wait_idle

   // Hand one request to a host and wait until it is taken
   task automatic launch(input int v, input logic [3:0] a);
      int k = 0;
      wait_idle(v);
      req[v] = 1'b1;
      raddr[v] = a;
      tick(1);
      while (busy[v] !== 1'b1 && k < 10)
      begin
         tick(1);
         k++;
      end
      req[v] = 1'b0;
   endtask : launch

   task automatic select(input int v, input logic [3:0] a);
      int exp_sw;
      exp_sw = (v == 0 && a == last_async) ? 0 : mcsc_pkg::SWITCH_CYC;
      sw_cyc[v] = 0;
      launch(v, a);
      wait_idle(v);
      tick(8);
      `CHK(ch_en[v], exp_onehot(a), "wrong channel closed")
      `CHK(sel[v], a, "selected channel wrong")
      `CHK(sw[v], 1'b0, "still switching when idle")
      `CHK(sw_cyc[v], exp_sw, "break interval length wrong")
      if (v == 0)
      begin
         last_async = a;
      end
      if (v == 2)
      begin
         `CHK(echo[2], {4'h0, last_ser}, "miso did not return previous byte")
         last_ser = a;
      end
      tick(20);
      `CHK(ch_en[v], exp_onehot(a), "selection drifted while idle")
   endtask : select

   task automatic do_reset();
      sys_rst_i = 1'b1;
      tick(12);
      for (int v = 0; v < NV; v++)
      begin
         `CHK(hiz[v], 1'b1, "output not high impedance in reset")
         `CHK(ch_en[v], 16'h0000, "switch closed in reset")
      end
      sys_rst_i = 1'b0;
      last_ser = 4'h0;
      last_async = 4'hf;
      for (int v = 0; v < NV; v++)
      begin
         wait_idle(v);
         `CHK(init_done[v], 1'b1, "address sweep not finished")
         if (v != 0)
         begin
            `CHK(ch_en[v], 16'h0001, "channel zero not closed after reset")
            `CHK(hiz[v], 1'b0, "still high impedance after reset")
         end
      end
   endtask : do_reset

   initial
   begin
      repeat (20000) @(posedge sys_clk_i);
      failures++;
      $display("unexpected at %0t: watchdog expired", $time);
      summarize();
   end

   initial
   begin
      seed = 32'hf2643a4b;
      failures = 0;
      n_compared = 0;
      last_ser = 4'h0;
      sys_rst_i = 1'b1;
      foreach (req[v])
      begin
         req[v] = 1'b0;
         raddr[v] = 4'h0;
      end
      do_reset();
      $display("test reset done");
      for (int v = 0; v < NV; v++)
         foreach (corners[i])
            select(v, corners[i]);
      $display("test corners done");
      repeat (12)
      begin
         for (int v = 0; v < NV; v++)
         begin
            rnd = $random(seed);
            select(v, rnd[3:0]);
         end
      end
      $display("test random done");
      launch(2, 4'h6);
      tick(10);
      do_reset();
      select(2, 4'h9);
      select(1, 4'h3);
      $display("test reset in frame done");
      summarize();
   end
endmodule : tb
